/* File: design/pac_readout.sv */
// Control of an eight channel peak sensing converter: acquisition sequence,
// peak latches, level loading, channel selection and dataway readout.
// Assumes an APB master that maps dataway cycles as F in PADDR[10:6] and
// A in PADDR[5:2]; analog pins are asynchronous, ADC_DATA stable while done.
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "pac_defines.svh"

// Contract
// - Sequential suppressed readout returns one word per accepted channel, at most 8.
// - Sequential unsuppressed readout returns exactly 8 words in channel order.
// - Subaddress 14 returns the header word (word count and status byte), subaddress 15 the hit pattern.
// - Bit 16 carries overflow only while the overflow tag bit is 0.
// - Bits 12..1 hold the result; bits 15..13 the channel while sub tag is 0.
// - Addressed mode returns channel n at subaddress n for 0..7.
// - Gate or test command starts acquisition, enabling peak detection.
// - Gate end blocks the gate and starts the settling delay.
// - Settling delay end sets busy and starts conversion.
// - While busy only readout and clear functions are accepted.
// - Threshold crossing sets a per channel latch enabling peak comparison.
// - Peak found latch closes the channel gate and holds its memory.
// - Common level loads only when idle, by function 20 subaddress 9.
// - Upper, lower and offset levels are written only when idle.
// - Before each conversion upper, offset and lower levels load by strobes.
// - Upper level code 0 means 85 percent, 255 means full scale.
// - Offset code 0 is minus 3, 128 zero, 255 plus 3 percent.
// - Lower level code 0 means 0, 255 means 10 percent.
// - Suppression converts only peaked channels between lower and upper level.
// - Unsuppressed or addressed mode converts all 8 channels.
// - Channel without peak keeps its multiplexer path disabled.
// - Sequential read of the last word clears and returns to idle.
// - Request enabled asserts look-at-me after conversion when data waits.
// - Each sequential read advances the read pointer at its strobe.
module pac_readout (
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic GATE,
	input wire logic [7:0] THRESHOLD_CROSS,
	input wire logic [7:0] PEAK_FALL,
	input wire logic ADC_DONE,
	input wire logic [11:0] ADC_DATA,
	input wire logic ADC_RANGE_EXCEEDED,
	input wire logic ABOVE_LOWER,
	input wire logic BELOW_UPPER,
	output logic ADC_START,
	output logic [2:0] MUX_SELECT,
	output logic MUX_ENABLE,
	output pac_pkg::pac_byte_type LEVEL_DATA,
	output logic UPPER_LEVEL_LOAD,
	output logic OFFSET_LEVEL_LOAD,
	output logic LOWER_LEVEL_LOAD,
	output pac_pkg::pac_byte_type COMMON_LEVEL,
	output logic COMMON_LEVEL_LOAD,
	output logic PEAK_ENABLE,
	output logic [7:0] INPUT_GATE_OPEN,
	output logic [7:0] HOLD,
	output logic BUSY,
	output logic LAM
);
	import pac_pkg::*;

	// --------------------------------------------------------------
	// State record
	// --------------------------------------------------------------
	typedef struct packed {
		pac_state_type state;
		logic [19:0] s1;
		logic [19:0] s2;
		logic [19:0] s3;
		logic [19:0] filt;
		logic gate_prev;
		logic test_run;
		logic [7:0] cnt;
		logic [2:0] ch;
		logic [7:0] thr_latch;
		logic [7:0] peak_latch;
		logic [7:0][15:0] mem;
		logic [3:0] wcount;
		logic [3:0] rptr;
		logic [7:0] hits;
		logic lam;
		logic [15:0] status;
		logic [7:0] common;
		logic [7:0][7:0] upper;
		logic [7:0][7:0] lower;
		logic [7:0][7:0] offset;
		logic [7:0] level_data;
		logic upper_load;
		logic offset_load;
		logic lower_load;
		logic common_load;
		logic [2:0] mux_sel;
		logic mux_en;
		logic adc_start;
		logic [7:0] gate_open;
		logic busy;
		logic pready;
		logic cmd_q;
		logic pslverr;
		logic [31:0] prdata;
	} pac_reg_type;

	pac_reg_type r_reg;
	pac_reg_type r_next;

	// Dataway word from a stored entry; tags set in the status word blank fields
	function automatic logic [31:0] pac_format(input logic [15:0] entry, input logic [15:0] sw);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[15] = entry[15] & ~sw[`PAC_SW_RANGE_TAG];
		w[14:12] = entry[14:12] & {3{~sw[`PAC_SW_SUB]}};
		w[11:0] = entry[11:0];
		return w;
	endfunction

	// --------------------------------------------------------------
	// Decode helpers
	// --------------------------------------------------------------
	logic [4:0] fcode;
	logic [3:0] sub;
	logic addr_ok;
	logic setup;
	logic strobe;
	logic idle;
	logic seq_mode;
	logic zs_active;
	logic gate_s;
	logic done_s;
	logic window_ok;
	assign fcode = PADDR[`PAC_F_LSB+4:`PAC_F_LSB];
	assign sub = PADDR[`PAC_A_LSB+3:`PAC_A_LSB];
	assign addr_ok = (PADDR[31:`PAC_ADDR_TOP+1] == 21'h00_0000) && (PADDR[1:0] == 2'b00);
	assign setup = PSEL && !PENABLE;
	assign strobe = PSEL && PENABLE && r_reg.pready;
	assign idle = (r_reg.state == ST_IDLE);
	assign seq_mode = r_reg.status[`PAC_SW_SEQ_READ];
	// Suppression counts only with sequential readout selected
	assign zs_active = r_reg.status[`PAC_SW_ZERO_SUPP] && seq_mode;
	assign gate_s = r_reg.filt[0];
	assign done_s = r_reg.filt[17];
	assign window_ok = r_reg.filt[18] && r_reg.filt[19];

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb begin
		logic do_clear;
		logic start_test;
		logic ok;
		logic q;
		logic [31:0] rd;
		do_clear = 1'b0;
		start_test = 1'b0;
		ok = 1'b0;
		q = 1'b0;
		rd = 32'h0000_0000;
		r_next = r_reg;
		r_next.upper_load = 1'b0;
		r_next.offset_load = 1'b0;
		r_next.lower_load = 1'b0;
		r_next.common_load = 1'b0;
		r_next.adc_start = 1'b0;
		// Pins pass three stages; a change counts once stages two and three agree
		r_next.s1 = {BELOW_UPPER, ABOVE_LOWER, ADC_DONE, PEAK_FALL, THRESHOLD_CROSS, GATE};
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		r_next.filt = (r_reg.s2 & ~(r_reg.s2 ^ r_reg.s3)) | (r_reg.filt & (r_reg.s2 ^ r_reg.s3));
		r_next.gate_prev = gate_s;

		// Setup phase: decide the answer now so the access phase needs no wait
		r_next.pready = setup;
		if (setup) begin
			case (fcode)
				`PAC_F_READ, `PAC_F_READ_CLR: begin
					if (sub == `PAC_A_HEADER) begin
						ok = 1'b1;
						q = r_reg.busy;
						rd = {20'h0_0000, r_reg.wcount, r_reg.status[7:0]};
					end else if (sub == `PAC_A_PATTERN) begin
						ok = 1'b1;
						q = r_reg.busy;
						rd = {24'h00_0000, r_reg.hits};
					end else if (sub[3] == 1'b0 && seq_mode) begin
						ok = (sub == 4'd0);
						q = (r_reg.state == ST_READOUT) && (r_reg.rptr < r_reg.wcount);
						rd = pac_format(r_reg.mem[r_reg.rptr[2:0]], r_reg.status);
					end else if (sub[3] == 1'b0) begin
						ok = 1'b1;
						q = (r_reg.state == ST_READOUT);
						rd = pac_format(r_reg.mem[sub[2:0]], r_reg.status);
					end
				end
				`PAC_F_RD_LEVEL: begin
					ok = 1'b1;
					q = !r_reg.busy;
					rd = {24'h00_0000, sub[3] ? r_reg.lower[sub[2:0]] : r_reg.upper[sub[2:0]]};
				end
				`PAC_F_RD_PARAM: begin
					ok = (sub[3] == 1'b0) || (sub == `PAC_A_COMMON) || (sub == `PAC_A_STATUS);
					q = !r_reg.busy;
					if (sub == `PAC_A_COMMON) begin
						rd = {24'h00_0000, r_reg.common};
					end else if (sub == `PAC_A_STATUS) begin
						rd = {16'h0000, r_reg.status};
					end else begin
						rd = {24'h00_0000, r_reg.offset[sub[2:0]]};
					end
				end
				`PAC_F_TEST_LAM: begin
					ok = (sub == 4'd0);
					q = r_reg.lam && !r_reg.busy;
				end
				`PAC_F_CLEAR, `PAC_F_CLR_LAM: begin
					ok = (sub == 4'd0);
					q = 1'b1;
				end
				`PAC_F_WR_LEVEL: begin
					ok = 1'b1;
					q = idle;
				end
				`PAC_F_WR_PARAM: begin
					ok = (sub[3] == 1'b0) || (sub == `PAC_A_COMMON) || (sub == `PAC_A_STATUS);
					q = idle;
				end
				`PAC_F_TEST: begin
					ok = (sub == 4'd0);
					q = idle;
				end
				default: begin
					ok = 1'b0;
				end
			endcase
			ok = ok && addr_ok;
			r_next.cmd_q = ok && q;
			// Refused or unmapped commands answer with an error and no effect
			r_next.pslverr = !(ok && q);
			r_next.prdata = (ok && q && !PWRITE) ? rd : 32'h0000_0000;
		end else if (strobe) begin
			r_next.pslverr = 1'b0;
			r_next.prdata = 32'h0000_0000;
		end

		// Access phase strobe: the command takes effect here
		if (strobe && r_reg.cmd_q) begin
			case (fcode)
				`PAC_F_READ, `PAC_F_READ_CLR: begin
					if (sub == 4'd0 && seq_mode) begin
						r_next.rptr = r_reg.rptr + 4'd1;
						if (r_reg.rptr + 4'd1 >= r_reg.wcount) begin
							do_clear = 1'b1;
						end
					end else if (sub == `PAC_A_PATTERN && fcode == `PAC_F_READ_CLR) begin
						r_next.lam = 1'b0;
					end else if (sub == `PAC_A_LAST_CHAN && fcode == `PAC_F_READ_CLR && !seq_mode) begin
						do_clear = 1'b1;
					end
				end
				`PAC_F_CLEAR: begin
					do_clear = 1'b1;
				end
				`PAC_F_CLR_LAM: begin
					r_next.lam = 1'b0;
				end
				`PAC_F_WR_LEVEL: begin
					// Codes stored raw; the analog side scales them to full scale
					if (sub[3]) begin
						r_next.lower[sub[2:0]] = PWDATA[7:0];
					end else begin
						r_next.upper[sub[2:0]] = PWDATA[7:0];
					end
				end
				`PAC_F_WR_PARAM: begin
					if (sub == `PAC_A_COMMON) begin
						r_next.common = PWDATA[7:0];
						r_next.common_load = 1'b1;
					end else if (sub == `PAC_A_STATUS) begin
						r_next.status = PWDATA[15:0] & `PAC_STATUS_MASK;
					end else begin
						r_next.offset[sub[2:0]] = PWDATA[7:0];
					end
				end
				`PAC_F_TEST: begin
					start_test = 1'b1;
				end
				default: begin
					do_clear = 1'b0;
				end
			endcase
		end

		// Acquisition and conversion sequence
		case (r_reg.state)
			ST_IDLE: begin
				if ((gate_s && !r_reg.gate_prev) || start_test) begin
					r_next.state = ST_ACQ;
					r_next.test_run = start_test;
					r_next.cnt = 8'h00;
					r_next.thr_latch = 8'h00;
					r_next.peak_latch = 8'h00;
				end
			end
			ST_ACQ: begin
				r_next.thr_latch = r_reg.thr_latch | r_reg.filt[8:1];
				r_next.peak_latch = r_reg.peak_latch | (r_reg.thr_latch & r_reg.filt[16:9]);
				r_next.cnt = r_reg.cnt + 8'h01;
				if (r_reg.test_run ? (r_reg.cnt == 8'(`PAC_TEST_CYC - 1)) : !gate_s) begin
					r_next.state = ST_SETTLE;
					r_next.cnt = 8'h00;
				end
			end
			ST_SETTLE: begin
				// Gate stays ignored: only the idle and acquisition states look at it
				r_next.cnt = r_reg.cnt + 8'h01;
				if (r_reg.cnt == 8'(`PAC_SETTLE_CYC - 1)) begin
					r_next.state = ST_LOAD_UP;
					r_next.ch = 3'd0;
					r_next.wcount = 4'd0;
					r_next.rptr = 4'd0;
					r_next.hits = 8'h00;
				end
			end
			ST_LOAD_UP: begin
				r_next.mux_sel = r_reg.ch;
				r_next.mux_en = r_reg.peak_latch[r_reg.ch];
				r_next.level_data = r_reg.upper[r_reg.ch];
				r_next.upper_load = 1'b1;
				r_next.state = ST_LOAD_OFS;
			end
			ST_LOAD_OFS: begin
				r_next.level_data = r_reg.offset[r_reg.ch];
				r_next.offset_load = 1'b1;
				r_next.state = ST_LOAD_LOW;
			end
			ST_LOAD_LOW: begin
				r_next.level_data = r_reg.lower[r_reg.ch];
				r_next.lower_load = 1'b1;
				r_next.state = ST_LEVEL_WAIT;
				r_next.cnt = 8'h00;
			end
			ST_LEVEL_WAIT: begin
				// Window comparators need the sync latency after the levels change
				r_next.cnt = r_reg.cnt + 8'h01;
				if (r_reg.cnt == 8'(`PAC_SYNC_CYC)) begin
					r_next.state = ST_CONVERT;
				end
			end
			ST_CONVERT: begin
				r_next.cnt = 8'h00;
				if (!zs_active || (r_reg.peak_latch[r_reg.ch] && window_ok)) begin
					r_next.adc_start = 1'b1;
					r_next.state = ST_CONV_WAIT;
				end else if (r_reg.ch == 3'd7) begin
					r_next.state = ST_READOUT;
					r_next.lam = r_reg.status[`PAC_SW_CLE] && (r_reg.wcount != 4'd0);
				end else begin
					r_next.ch = r_reg.ch + 3'd1;
					r_next.state = ST_LOAD_UP;
				end
			end
			ST_CONV_WAIT: begin
				// A stale done needs one cycle to drop, then the whole filter depth
				if (r_reg.cnt != 8'(`PAC_SYNC_CYC + 1)) begin
					r_next.cnt = r_reg.cnt + 8'h01;
				end else if (done_s) begin
					r_next.mem[r_reg.wcount[2:0]] = {ADC_RANGE_EXCEEDED, r_reg.ch, ADC_DATA};
					r_next.wcount = r_reg.wcount + 4'd1;
					r_next.hits[r_reg.ch] = 1'b1;
					if (r_reg.ch == 3'd7) begin
						r_next.state = ST_READOUT;
						r_next.lam = r_reg.status[`PAC_SW_CLE];
					end else begin
						r_next.ch = r_reg.ch + 3'd1;
						r_next.state = ST_LOAD_UP;
					end
				end
			end
			ST_READOUT: begin
				// Nothing accepted in sequential mode: release at once
				if (seq_mode && r_reg.wcount == 4'd0) begin
					do_clear = 1'b1;
				end
			end
			default: begin
				r_next.state = ST_IDLE;
			end
		endcase

		// Clear leaves parameters and status word untouched
		if (do_clear) begin
			r_next.state = ST_IDLE;
			r_next.thr_latch = 8'h00;
			r_next.peak_latch = 8'h00;
			r_next.wcount = 4'd0;
			r_next.rptr = 4'd0;
			r_next.hits = 8'h00;
			r_next.lam = 1'b0;
			r_next.mux_en = 1'b0;
		end
		r_next.gate_open = {8{r_next.state == ST_ACQ}} & ~r_next.peak_latch;
		r_next.busy = !(r_next.state == ST_IDLE || r_next.state == ST_ACQ || r_next.state == ST_SETTLE);
	end

	// State register
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			r_reg <= '0;
			r_reg.state <= ST_IDLE;
			r_reg.status <= `PAC_STATUS_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from the state record
	assign PRDATA = r_reg.prdata;
	assign PREADY = r_reg.pready;
	assign PSLVERR = r_reg.pslverr;
	assign ADC_START = r_reg.adc_start;
	assign MUX_SELECT = r_reg.mux_sel;
	assign MUX_ENABLE = r_reg.mux_en;
	assign LEVEL_DATA = r_reg.level_data;
	assign UPPER_LEVEL_LOAD = r_reg.upper_load;
	assign OFFSET_LEVEL_LOAD = r_reg.offset_load;
	assign LOWER_LEVEL_LOAD = r_reg.lower_load;
	assign COMMON_LEVEL = r_reg.common;
	assign COMMON_LEVEL_LOAD = r_reg.common_load;
	assign PEAK_ENABLE = r_reg.state[1]; // One-hot bit of the acquisition state
	assign INPUT_GATE_OPEN = r_reg.gate_open;
	assign HOLD = r_reg.peak_latch;
	assign BUSY = r_reg.busy;
	assign LAM = r_reg.lam;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);

	level_write_idle_a: assert property ((strobe && fcode == `PAC_F_WR_LEVEL && !idle) |=> $stable(r_reg.upper) && $stable(r_reg.lower)) else $error("level written outside idle");
	common_load_idle_a: assert property (COMMON_LEVEL_LOAD |-> $past(idle) && $past(fcode) == `PAC_F_WR_PARAM && $past(sub) == `PAC_A_COMMON) else $error("common level loaded outside idle");
	busy_reject_a: assert property ((setup && r_reg.busy && (fcode inside {`PAC_F_RD_PARAM, `PAC_F_TEST, `PAC_F_WR_LEVEL, `PAC_F_WR_PARAM})) |=> PSLVERR) else $error("command accepted while busy");
	settle_to_busy_a: assert property ((r_reg.state == ST_SETTLE && r_reg.cnt == 8'(`PAC_SETTLE_CYC - 1) && !(strobe && r_reg.cmd_q && fcode == `PAC_F_CLEAR)) |=> BUSY ##1 (UPPER_LEVEL_LOAD && MUX_SELECT == 3'd0)) else $error("busy missing after settling");
	gate_blocked_a: assert property ((r_reg.state == ST_SETTLE) |=> r_reg.state != ST_ACQ) else $error("gate restarted during settling");
	load_order_a: assert property (UPPER_LEVEL_LOAD |=> OFFSET_LEVEL_LOAD ##1 LOWER_LEVEL_LOAD) else $error("level strobes out of order");
	peak_gate_a: assert property ((INPUT_GATE_OPEN & HOLD) == 8'h00) else $error("gate open on held channel");
	mux_path_a: assert property (UPPER_LEVEL_LOAD |-> MUX_ENABLE == HOLD[MUX_SELECT]) else $error("multiplexer path wrong");
	suppress_start_a: assert property ((ADC_START && $past(zs_active)) |-> HOLD[$past(r_reg.ch)]) else $error("suppressed channel converted");
	hit_set_a: assert property ((r_reg.wcount == $past(r_reg.wcount) + 4'd1) |-> r_reg.hits[$past(r_reg.ch)]) else $error("hit bit missing");
	seq_advance_a: assert property ((strobe && r_reg.cmd_q && seq_mode && fcode == `PAC_F_READ && sub == 4'd0) |=> (r_reg.rptr == $past(r_reg.rptr) + 4'd1) || idle) else $error("read pointer stuck");

	seq_drain_c: cover property ((r_reg.state == ST_READOUT && seq_mode) ##[1:1000] idle);
	addr_read_c: cover property (strobe && r_reg.cmd_q && !seq_mode && fcode == `PAC_F_READ && sub == 4'd3);
	test_start_c: cover property (idle ##1 r_reg.state == ST_ACQ && r_reg.test_run);
endmodule
`default_nettype wire

/* File: shared/pac_defines.svh */
// Constants of the peak converter readout block: dataway mapping on APB,
// status word layout, reset values and timing counts.
// Assumes a 100 MHz REF_CLK; included by bare name.
`ifndef PAC_DEFINES_SVH
`define PAC_DEFINES_SVH

// --------------------------------------------------------------
// APB address layout: function code and subaddress fields
// --------------------------------------------------------------
`define PAC_F_LSB 6
`define PAC_A_LSB 2
`define PAC_ADDR_TOP 10

// --------------------------------------------------------------
// Function codes and subaddresses
// --------------------------------------------------------------
`define PAC_F_READ 5'd0
`define PAC_F_RD_LEVEL 5'd1
`define PAC_F_READ_CLR 5'd2
`define PAC_F_RD_PARAM 5'd4
`define PAC_F_TEST_LAM 5'd8
`define PAC_F_CLEAR 5'd9
`define PAC_F_CLR_LAM 5'd10
`define PAC_F_WR_LEVEL 5'd17
`define PAC_F_WR_PARAM 5'd20
`define PAC_F_TEST 5'd25
`define PAC_A_COMMON 4'd9
`define PAC_A_STATUS 4'd14
`define PAC_A_HEADER 4'd14
`define PAC_A_PATTERN 4'd15
`define PAC_A_LAST_CHAN 4'd7

// --------------------------------------------------------------
// Status word fields and header word fields
// --------------------------------------------------------------
`define PAC_SW_SUB 9
`define PAC_SW_FRONT_BUS 10
`define PAC_SW_RANGE_TAG 11
`define PAC_SW_ZERO_SUPP 12
`define PAC_SW_SEQ_READ 13
`define PAC_SW_CLE 14
`define PAC_STATUS_RST 16'h7eff
`define PAC_STATUS_MASK 16'h7eff
`define PAC_HDR_COUNT_LSB 8

// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define PAC_CLK_NS 10
`define PAC_SETTLE_NS 2000
`define PAC_SETTLE_CYC ((`PAC_SETTLE_NS + `PAC_CLK_NS - 1) / `PAC_CLK_NS)
`define PAC_TEST_NS 1000
`define PAC_TEST_CYC (`PAC_TEST_NS / `PAC_CLK_NS)
`define PAC_SYNC_CYC 4

`endif

/* File: shared/pac_pkg.sv */
// Types shared by the peak converter readout block.
// Assumes nothing of its surroundings.
package pac_pkg;
	typedef enum logic [9:0] {
		ST_IDLE = 10'b00_0000_0001,
		ST_ACQ = 10'b00_0000_0010,
		ST_SETTLE = 10'b00_0000_0100,
		ST_LOAD_UP = 10'b00_0000_1000,
		ST_LOAD_OFS = 10'b00_0001_0000,
		ST_LOAD_LOW = 10'b00_0010_0000,
		ST_LEVEL_WAIT = 10'b00_0100_0000,
		ST_CONVERT = 10'b00_1000_0000,
		ST_CONV_WAIT = 10'b01_0000_0000,
		ST_READOUT = 10'b10_0000_0000
	} pac_state_type;
	typedef logic [7:0] pac_byte_type;
	typedef logic [15:0] pac_entry_type;
endpackage

/* File: bench/pac_adc_model.sv */
// Behavioural converter that answers the block's start pulses.
// Assumes one REF_CLK domain and a mux that is settled at the start pulse.
`timescale 1ns/100ps
`default_nettype none
module pac_adc_model (
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic ADC_START,
	input wire logic [2:0] MUX_SELECT,
	output logic ADC_DONE,
	output logic [11:0] ADC_DATA,
	output logic ADC_RANGE_EXCEEDED
);
	logic [3:0] cnt_reg;
	logic [2:0] ch_reg;
	logic [11:0] val;
	// Done drops at once on start and rises after a fixed delay
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			cnt_reg <= 4'h0;
			ch_reg <= 3'h0;
			ADC_DONE <= 1'b0;
		end else if (ADC_START) begin
			ADC_DONE <= 1'b0;
			cnt_reg <= 4'h9;
			ch_reg <= MUX_SELECT;
		end else if (cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
			ADC_DONE <= (cnt_reg == 4'h1);
		end
	end
	// Outside done the lines show the inverse, so a late sample is caught
	assign val = 12'h123 + {9'h0, ch_reg};
	assign ADC_DATA = ADC_DONE ? val : ~val;
	assign ADC_RANGE_EXCEEDED = ADC_DONE ? (ch_reg == 3'h5) : (ch_reg != 3'h5);
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench: APB dataway cycles against the readout block.
// Assumes the converter model and the design files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clk, nrst, psel, pen, pwr, gate, adone, arng, busy, lam, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata;
	logic [7:0] thr, peak, hold, cmn, ldat, gopen, lvl_up, lvl_ofs;
	logic [11:0] adata;
	logic [2:0] msel;
	logic astart, pk_en, upl, ofl;
	int err_total, checked;
	// Channel 3 always reads as above its upper level, so suppression must drop it
	pac_readout i_dut (.REF_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.GATE(gate), .THRESHOLD_CROSS(thr), .PEAK_FALL(peak), .ADC_DONE(adone), .ADC_DATA(adata),
		.ADC_RANGE_EXCEEDED(arng), .ABOVE_LOWER(1'b1), .BELOW_UPPER(msel != 3'd3), .ADC_START(astart),
		.MUX_SELECT(msel), .MUX_ENABLE(), .LEVEL_DATA(ldat), .UPPER_LEVEL_LOAD(upl), .OFFSET_LEVEL_LOAD(ofl),
		.LOWER_LEVEL_LOAD(), .COMMON_LEVEL(cmn), .COMMON_LEVEL_LOAD(), .PEAK_ENABLE(pk_en),
		.INPUT_GATE_OPEN(gopen), .HOLD(hold), .BUSY(busy), .LAM(lam));
	pac_adc_model i_adc (.REF_CLK(clk), .NRST(nrst), .ADC_START(astart), .MUX_SELECT(msel),
		.ADC_DONE(adone), .ADC_DATA(adata), .ADC_RANGE_EXCEEDED(arng));
	// Keeps the level codes strobed out for channel 3 upper and channel 2 offset
	always @(posedge clk) begin
		if (upl && msel == 3'd3)
			lvl_up <= ldat;
		if (ofl && msel == 3'd2)
			lvl_ofs <= ldat;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; holds the request until pready is sampled high or 50 cycles pass
	task automatic apb(input logic [4:0] f, input logic [3:0] a, input logic wr, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= {21'h0, f, a, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// A missing answer counts as a mismatch, not as a quiet pass
		if (pready !== 1'b1) begin
			err_total++;
			$display("[ERR] %0t no ready", $time);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rq(input logic [4:0] f, input logic [3:0] a, input logic [31:0] exp, input logic xer);
		logic [31:0] rd;
		logic er;
		apb(f, a, 1'b0, 32'h0, rd, er);
		chk({er, rd[30:0]}, {xer, exp[30:0]});
	endtask
	task automatic wq(input logic [4:0] f, input logic [3:0] a, input logic [31:0] wd, input logic xer);
		logic [31:0] rd;
		logic er;
		apb(f, a, 1'b1, wd, rd, er);
		chk({31'h0, er}, {31'h0, xer});
	endtask
	// Starts a test acquisition and waits, bounded, for the request
	task automatic run_test();
		int n;
		n = 0;
		wq(5'd25, 4'd0, 32'h0, 1'b0);
		@(posedge clk);
		chk({23'h0, pk_en, gopen}, 32'h0000_01ff);
		while (lam !== 1'b1 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		chk({30'h0, busy, lam}, 32'h0000_0003);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#300_000;
		err_total++;
		tally_and_finish();
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		{nrst, psel, pen, pwr, gate} = 5'b0;
		{paddr, pwdata, thr, peak} = 80'h0;
		err_total = 0;
		checked = 0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rq(5'd4, 4'd14, 32'h0000_7eff, 1'b0);
		wq(5'd17, 4'd3, 32'h0000_00a7, 1'b0);
		wq(5'd17, 4'd11, 32'h0000_0012, 1'b0);
		wq(5'd20, 4'd9, 32'h0000_003c, 1'b0);
		@(posedge clk);
		chk({24'h0, cmn}, 32'h0000_003c);
		wq(5'd20, 4'd2, 32'h0000_0080, 1'b0);
		rq(5'd4, 4'd2, 32'h0000_0080, 1'b0);
		rq(5'd1, 4'd3, 32'h0000_00a7, 1'b0);
		rq(5'd1, 4'd11, 32'h0000_0012, 1'b0);
		// Sequential, no suppression, both tags off
		wq(5'd20, 4'd14, 32'h0000_605a, 1'b0);
		run_test();
		wq(5'd17, 4'd3, 32'h0000_0001, 1'b1);
		wq(5'd20, 4'd9, 32'h0000_0001, 1'b1);
		rq(5'd8, 4'd0, 32'h0, 1'b1);
		chk({24'h0, lvl_up}, 32'h0000_00a7);
		chk({24'h0, lvl_ofs}, 32'h0000_0080);
		rq(5'd0, 4'd14, 32'h0000_085a, 1'b0);
		rq(5'd0, 4'd15, 32'h0000_00ff, 1'b0);
		for (int c = 0; c < 8; c++)
			rq(c[0] ? 5'd2 : 5'd0, 4'd0, {16'h0, c == 5, c[2:0], 12'h123 + c[11:0]}, 1'b0);
		@(posedge clk);
		chk({30'h0, busy, lam}, 32'h0);
		// Sequential with suppression, tags on: four peaked, channel 3 out of window
		wq(5'd20, 4'd14, 32'h0000_7e5a, 1'b0);
		thr <= 8'h2d;
		peak <= 8'h2d;
		run_test();
		chk({24'h0, hold}, 32'h0000_002d);
		rq(5'd2, 4'd14, 32'h0000_035a, 1'b0);
		rq(5'd0, 4'd15, 32'h0000_0025, 1'b0);
		rq(5'd0, 4'd0, 32'h0000_0123, 1'b0);
		rq(5'd2, 4'd0, 32'h0000_0125, 1'b0);
		rq(5'd0, 4'd0, 32'h0000_0128, 1'b0);
		rq(5'd0, 4'd0, 32'h0, 1'b1);
		thr <= 8'h0;
		peak <= 8'h0;
		// Addressed mode ignores suppression
		wq(5'd20, 4'd14, 32'h0000_505a, 1'b0);
		run_test();
		rq(5'd0, 4'd7, 32'h0000_712a, 1'b0);
		rq(5'd0, 4'd5, 32'h0000_d128, 1'b0);
		rq(5'd0, 4'd0, 32'h0000_0123, 1'b0);
		wq(5'd10, 4'd0, 32'h0, 1'b0);
		@(posedge clk);
		chk({30'h0, busy, lam}, 32'h0000_0002);
		rq(5'd2, 4'd7, 32'h0000_712a, 1'b0);
		@(posedge clk);
		chk({31'h0, busy}, 32'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
